// [rtl/eeprom_host.sv]
// Host controller that drives a paged parallel EEPROM through its pins
`timescale 1ns/1ns
module eeprom_host #(
  parameter int unsigned POWER_CYCLES = eeprom_host_pkg::POWER_CYC,
  parameter int unsigned WRITE_CYCLE_CYCLES = eeprom_host_pkg::WRITE_CYCLE_CYC,
  parameter int unsigned ERASE_CYCLES = eeprom_host_pkg::ERASE_CYC,
  parameter int unsigned SETUP_CYCLES = eeprom_host_pkg::SETUP_CYC,
  parameter logic [eeprom_host_pkg::ADDR_W-1:0] CMD_A = eeprom_host_pkg::CMD_ADDR_A,
  parameter logic [eeprom_host_pkg::ADDR_W-1:0] CMD_B = eeprom_host_pkg::CMD_ADDR_B,
  parameter logic [eeprom_host_pkg::DATA_W-1:0] DAT_A = eeprom_host_pkg::CMD_DATA_A,
  parameter logic [eeprom_host_pkg::DATA_W-1:0] DAT_B = eeprom_host_pkg::CMD_DATA_B,
  parameter logic [eeprom_host_pkg::DATA_W-1:0] DAT_UNLOCK = eeprom_host_pkg::CMD_DATA_UNLOCK,
  parameter logic [eeprom_host_pkg::DATA_W-1:0] DAT_DIS3 = eeprom_host_pkg::CMD_DATA_DIS3,
  parameter logic [eeprom_host_pkg::DATA_W-1:0] DAT_DIS6 = eeprom_host_pkg::CMD_DATA_DIS6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic powerGood,
  input wire logic reqValid,
  output logic reqReady,
  input wire eeprom_host_pkg::op_t reqOp,
  input wire logic reqProtected,
  input wire logic reqIdRow,
  input wire logic [eeprom_host_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [eeprom_host_pkg::SLOT_W:0] reqCount,
  input wire logic loadValid,
  input wire logic [eeprom_host_pkg::SLOT_W-1:0] loadSlot,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] loadData,
  output logic doneValid,
  output logic [eeprom_host_pkg::DATA_W-1:0] doneData,
  output logic doneTimeout,
  output logic [eeprom_host_pkg::ADDR_W-1:0] memAddr,
  output logic memCe_b,
  output logic memOe_b,
  output logic memWe_b,
  output logic idHighVolt,
  output logic eraseHighVolt,
  output logic [eeprom_host_pkg::DATA_W-1:0] memDataOut,
  output logic memDataOe,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] memDataIn
);
  import eeprom_host_pkg::*;

  typedef enum {
    S_POWER, S_IDLE, S_LOAD, S_SETUP, S_STROBE, S_RECOVER, S_READ, S_GATE_HIGH, S_POLL,
    S_ERASE, S_DONE
  } state_t;

  state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] busy_reg, busy_next;
  logic [1:0] cmdIdx_reg, cmdIdx_next;
  logic [SLOT_W:0] byteIdx_reg, byteIdx_next;
  logic [SLOT_W:0] count_reg;
  op_t op_reg;
  pfx_t pfx_reg;
  logic idRow_reg;
  logic [ADDR_W-1:0] page_reg;
  logic [DATA_W-1:0] lastRead_reg, prevRead_reg;
  logic polled_reg, polledTwice_reg;
  logic [1:0] pgSync_reg;
  logic [DATA_W-1:0] dinMeta_reg, dinSync_reg;

  // Input pins pass two flip-flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pgSync_reg <= 2'b00;
      dinMeta_reg <= '0;
      dinSync_reg <= '0;
    end else if (clkEn) begin
      pgSync_reg <= {pgSync_reg[0], powerGood};
      dinMeta_reg <= memDataIn;
      dinSync_reg <= dinMeta_reg;
    end
  end
  wire pwrOk = pgSync_reg[1];

  // Page buffer holding bytes to write
  wire bufWr = (state_reg == S_LOAD) && loadValid;
  wire [SLOT_W-1:0] bufRdSlot = SLOT_W'(page_reg[SLOT_W-1:0] + byteIdx_reg[SLOT_W-1:0]);
  wire [DATA_W-1:0] bufData;
  wire bufLoaded;
  page_buffer u_buf (
    .clk(clk), .rst_b(rst_b), .clkEn(clkEn), .wrEn(bufWr), .wrSlot(loadSlot),
    .wrData(loadData), .clearMask(state_reg == S_IDLE), .rdSlot(bufRdSlot),
    .rdData(bufData), .rdLoaded(bufLoaded)
  );

  // Prefix selection from the requested operation
  wire disLong = (pfx_reg == PFX_DISABLE);
  logic [2:0] cmdStep_reg, cmdStep_next;
  wire [2:0] cmdTotal = disLong ? 3'd6 : 3'd3;
  wire cmdActive = (pfx_reg != PFX_NONE) && (cmdStep_reg != cmdTotal);
  wire [ADDR_W-1:0] cmdAddr = (cmdStep_reg == 3'd1 || cmdStep_reg == 3'd4) ? CMD_B : CMD_A;
  wire [DATA_W-1:0] cmdData =
      (cmdStep_reg == 3'd1 || cmdStep_reg == 3'd4) ? DAT_B :
      (cmdStep_reg == 3'd0 || cmdStep_reg == 3'd3) ? DAT_A :
      (cmdStep_reg == 3'd2) ? (pfx_reg == PFX_UNLOCK ? DAT_UNLOCK :
                               disLong ? DAT_DIS3 : DAT_UNLOCK) : DAT_DIS6;
  // Page address stays from first to last strobe; low bits pick slot
  wire [ADDR_W-1:0] dataAddr = {page_reg[ADDR_W-1:SLOT_W], bufRdSlot};
  wire lastByte = (byteIdx_reg + 1'b1) >= count_reg;
  // Done once two reads in a row agree on the toggle and polled bits
  wire toggleStill = (lastRead_reg[TOGGLE_BIT] == prevRead_reg[TOGGLE_BIT]);
  wire pollDone = polledTwice_reg && toggleStill
      && (lastRead_reg[POLL_BIT] == prevRead_reg[POLL_BIT]);

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg == CNT_ZERO) ? CNT_ZERO : cnt_reg - CNT_ONE;
    busy_next = (busy_reg == CNT_ZERO) ? CNT_ZERO : busy_reg - CNT_ONE;
    cmdIdx_next = cmdIdx_reg;
    cmdStep_next = cmdStep_reg;
    byteIdx_next = byteIdx_reg;
    case (state_reg)
      S_POWER: if (pwrOk && cnt_reg == CNT_ZERO) state_next = S_IDLE;
      S_IDLE: if (reqValid) begin
        cmdStep_next = 3'd0;
        byteIdx_next = '0;
        state_next = (reqOp == OP_PAGE_WRITE) ? S_LOAD :
                     (reqOp == OP_ERASE) ? S_ERASE : (reqOp == OP_READ) ? S_READ : S_SETUP;
        cnt_next = (reqOp == OP_ERASE) ? CNT_ZERO + SETUP_CYCLES[CNT_W-1:0] :
                   CNT_ZERO + READ_CYC[CNT_W-1:0];
      end
      S_LOAD: if (!loadValid) state_next = S_SETUP;
      S_SETUP: begin
        state_next = S_STROBE;
        cnt_next = CNT_ZERO + WRITE_PULSE_CYC[CNT_W-1:0];
      end
      S_STROBE: if (cnt_reg == CNT_ZERO) begin
        state_next = S_RECOVER;
        cnt_next = CNT_ZERO + WRITE_HIGH_CYC[CNT_W-1:0] + ADDR_HOLD_CYC[CNT_W-1:0];
      end
      S_RECOVER: if (cnt_reg == CNT_ZERO) begin
        if (cmdActive) cmdStep_next = cmdStep_reg + 3'd1;
        else byteIdx_next = byteIdx_reg + 1'b1;
        if (!cmdActive && lastByte || cmdActive && cmdStep_reg + 3'd1 == cmdTotal
            && count_reg == '0) begin
          state_next = S_READ;
          busy_next = CNT_ZERO + WRITE_CYCLE_CYCLES[CNT_W-1:0];
          cnt_next = CNT_ZERO + READ_CYC[CNT_W-1:0];
        end else state_next = S_SETUP;
      end
      S_READ: if (cnt_reg == CNT_ZERO) begin
        state_next = S_GATE_HIGH;
        cnt_next = CNT_ZERO + OE_HIGH_CYC[CNT_W-1:0];
      end
      S_GATE_HIGH: if (cnt_reg == CNT_ZERO) begin
        if (op_reg == OP_READ) state_next = S_DONE;
        else if (pollDone) state_next = S_DONE;
        else if (busy_reg == CNT_ZERO && polled_reg) state_next = S_DONE;
        else begin
          state_next = S_READ;
          cnt_next = CNT_ZERO + READ_CYC[CNT_W-1:0];
        end
      end
      S_ERASE: if (cnt_reg == CNT_ZERO) begin
        if (cmdIdx_reg == 2'd2) state_next = S_DONE;
        else begin
          cmdIdx_next = cmdIdx_reg + 2'd1;
          cnt_next = (cmdIdx_reg == 2'd0) ? CNT_ZERO + ERASE_CYCLES[CNT_W-1:0] :
                     CNT_ZERO + SETUP_CYCLES[CNT_W-1:0];
        end
      end
      S_DONE: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // Request capture and sequence state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= S_POWER;
      cnt_reg <= CNT_ZERO + POWER_CYCLES[CNT_W-1:0];
      busy_reg <= CNT_ZERO;
      cmdIdx_reg <= 2'd0;
      cmdStep_reg <= 3'd0;
      byteIdx_reg <= '0;
      count_reg <= '0;
      op_reg <= OP_READ;
      pfx_reg <= PFX_NONE;
      idRow_reg <= 1'b0;
      page_reg <= '0;
    end else if (clkEn) begin
      state_reg <= state_next;
      cnt_reg <= (state_reg == S_POWER && !pwrOk) ? CNT_ZERO + POWER_CYCLES[CNT_W-1:0]
                                                   : cnt_next;
      busy_reg <= busy_next;
      cmdIdx_reg <= (state_reg == S_IDLE) ? 2'd0 : cmdIdx_next;
      cmdStep_reg <= cmdStep_next;
      byteIdx_reg <= byteIdx_next;
      if (state_reg == S_IDLE && reqValid) begin
        op_reg <= reqOp;
        idRow_reg <= reqIdRow;
        page_reg <= reqIdRow ? (ID_ROW_BASE | reqAddr) : reqAddr;
        count_reg <= (reqOp == OP_PAGE_WRITE) ? reqCount : '0;
        pfx_reg <= (reqOp == OP_PROTECT_ON) ? PFX_ENABLE :
                   (reqOp == OP_PROTECT_OFF) ? PFX_DISABLE :
                   (reqOp == OP_PAGE_WRITE && reqProtected) ? PFX_UNLOCK : PFX_NONE;
      end
    end
  end

  // Poll bookkeeping: keep the last two reads of this operation
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lastRead_reg <= '0;
      prevRead_reg <= '0;
      polled_reg <= 1'b0;
      polledTwice_reg <= 1'b0;
    end else if (clkEn) begin
      if (state_reg == S_IDLE) begin
        polled_reg <= 1'b0;
        polledTwice_reg <= 1'b0;
      end else if (state_reg == S_READ && cnt_reg == CNT_ZERO) begin
        prevRead_reg <= lastRead_reg;
        lastRead_reg <= dinSync_reg;
        polled_reg <= 1'b1;
        polledTwice_reg <= polled_reg;
      end
    end
  end

  // Pin drive, all registered
  wire writing = (state_reg == S_STROBE) && (cmdActive || bufLoaded); // Unloaded slot: no strobe
  wire reading = (state_reg == S_READ);
  wire erasing = (state_reg == S_ERASE) && (cmdIdx_reg == 2'd1);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      memAddr <= '0;
      memCe_b <= 1'b1;
      memOe_b <= 1'b1;
      memWe_b <= 1'b1;
      idHighVolt <= 1'b0;
      eraseHighVolt <= 1'b0;
      memDataOut <= '0;
      memDataOe <= 1'b0;
      reqReady <= 1'b0;
      doneValid <= 1'b0;
      doneData <= '0;
      doneTimeout <= 1'b0;
    end else if (clkEn) begin
      memAddr <= cmdActive ? cmdAddr : (pfx_reg == PFX_NONE || state_reg == S_READ ||
                 state_reg == S_GATE_HIGH) ? (op_reg == OP_READ ? page_reg : dataAddr)
                 : dataAddr;
      memCe_b <= !(writing || reading || state_reg == S_SETUP || state_reg == S_ERASE);
      memOe_b <= !reading;
      memWe_b <= !(writing || erasing);
      idHighVolt <= idRow_reg && state_reg != S_IDLE && state_reg != S_POWER;
      eraseHighVolt <= (state_reg == S_ERASE);
      memDataOut <= cmdActive ? cmdData : bufData;
      memDataOe <= writing || state_reg == S_SETUP;
      reqReady <= (state_next == S_IDLE);
      doneValid <= (state_reg == S_DONE);
      if (state_reg == S_GATE_HIGH && cnt_reg == CNT_ZERO) begin
        doneData <= lastRead_reg;
        doneTimeout <= !pollDone && op_reg != OP_READ;
      end
    end
  end

  // Pin protocol assertions and covers on strobes, gates, power, done and ready
  a_strobe_width: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(memWe_b) && !eraseHighVolt |-> !memWe_b[*8]) else $error("strobe too short");
  a_write_gate: assert property (@(posedge clk) disable iff (!rst_b)
    !memWe_b |-> memOe_b && !memCe_b) else $error("write with gate low");
  a_power_block: assert property (@(posedge clk) disable iff (!rst_b)
    !pwrOk |=> memWe_b) else $error("write before power good");
  a_no_contend: assert property (@(posedge clk) disable iff (!rst_b)
    !memOe_b |-> !memDataOe) else $error("bus contention");
  a_done_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    doneValid && clkEn |=> !doneValid) else $error("done not a pulse");
  a_erase_hv: assert property (@(posedge clk) disable iff (!rst_b)
    !memWe_b && eraseHighVolt |-> !memCe_b) else $error("erase without select");
  a_ready_idle: assert property (@(posedge clk) disable iff (!rst_b)
    reqReady |-> memWe_b && memOe_b) else $error("ready while busy");
  a_read_gate: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(memOe_b) |-> !memCe_b && memWe_b) else $error("bad read gate");
  c_write: cover property (@(posedge clk) $fell(memWe_b) && !eraseHighVolt);
  c_erase: cover property (@(posedge clk) $rose(eraseHighVolt));
  c_done: cover property (@(posedge clk) doneValid && !doneTimeout);
endmodule : eeprom_host

// [rtl/eeprom_host_pkg.sv]
// Package: constants and types for the parallel EEPROM host controller
package eeprom_host_pkg;
  localparam int CLK_NS = 4;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 64;
  localparam int SLOT_W = 6;
  // Bus timing, nanoseconds, microseconds or milliseconds as printed
  localparam int WRITE_PULSE_NS = 100;
  localparam int WRITE_HIGH_NS = 50;
  localparam int ADDR_HOLD_NS = 50;
  localparam int READ_ACCESS_NS = 120;
  localparam int OE_HIGH_PULSE_NS = 150;
  localparam int SETUP_US = 5;
  localparam int ERASE_MS = 10;
  localparam int POWER_DELAY_MS = 5;
  localparam int WRITE_CYCLE_MS = 10;
  // Cycle counts; least times round up
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int OE_HIGH_CYC = (OE_HIGH_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC = (ERASE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int POWER_CYC = (POWER_DELAY_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000000 / CLK_NS;
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  // Identification row base
  localparam logic [ADDR_W-1:0] ID_ROW_BASE = 15'h7fc0;
  // Command sequence defaults (three address/data pairs, six for disable)
  localparam logic [ADDR_W-1:0] CMD_ADDR_A = 15'h5555;
  localparam logic [ADDR_W-1:0] CMD_ADDR_B = 15'h2aaa;
  localparam logic [DATA_W-1:0] CMD_DATA_A = 8'haa;
  localparam logic [DATA_W-1:0] CMD_DATA_B = 8'h55;
  localparam logic [DATA_W-1:0] CMD_DATA_UNLOCK = 8'ha0;
  localparam logic [DATA_W-1:0] CMD_DATA_DIS3 = 8'h80;
  localparam logic [DATA_W-1:0] CMD_DATA_DIS6 = 8'h20;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int ID_BIT = 9;
  localparam int SLOT_IDX_W = 3;
  // Requested operation
  typedef enum logic [2:0] {
    OP_READ, OP_PAGE_WRITE, OP_PROTECT_ON, OP_PROTECT_OFF, OP_ERASE
  } op_t;
  // Command-prefix kind
  typedef enum logic [1:0] {PFX_NONE, PFX_UNLOCK, PFX_ENABLE, PFX_DISABLE} pfx_t;
endpackage : eeprom_host_pkg

// [rtl/page_buffer.sv]
// Page buffer: 64 bytes with a load-mask and registered read
`timescale 1ns/1ns
module page_buffer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic [eeprom_host_pkg::SLOT_W-1:0] wrSlot,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] wrData,
  input wire logic clearMask,
  input wire logic [eeprom_host_pkg::SLOT_W-1:0] rdSlot,
  output logic [eeprom_host_pkg::DATA_W-1:0] rdData,
  output logic rdLoaded
);
  import eeprom_host_pkg::*;
  logic [DATA_W-1:0] mem [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] loadMask_reg;
  // Storage and registered read port
  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (wrEn) mem[wrSlot] <= wrData;
      rdData <= mem[rdSlot];
    end
  end
  // Marks which slots hold data for this page
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      loadMask_reg <= '0;
      rdLoaded <= 1'b0;
    end else if (clkEn) begin
      if (clearMask) loadMask_reg <= '0;
      else if (wrEn) loadMask_reg[wrSlot] <= 1'b1;
      rdLoaded <= loadMask_reg[rdSlot];
    end
  end
endmodule : page_buffer

// [dv/eeprom_dev_model.sv]
// Behavioural model of the paged parallel EEPROM on the far side of the host
`timescale 1ns/1ns
module eeprom_dev_model #(
  parameter int WIN = 200,
  parameter int PROG = 120,
  parameter int ERASE_MIN = 60
) (
  input wire logic clk,
  input wire logic [eeprom_host_pkg::ADDR_W-1:0] memAddr,
  input wire logic memCe_b,
  input wire logic memOe_b,
  input wire logic memWe_b,
  input wire logic idHighVolt,
  input wire logic eraseHighVolt,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] memDataOut,
  output logic [eeprom_host_pkg::DATA_W-1:0] memDataIn
);
  import eeprom_host_pkg::*;
  logic [7:0] mem [0:32767];
  logic [7:0] idMem [0:63];
  logic [7:0] page [0:63];
  logic [63:0] loaded = '0;
  logic [14:0] pageAddr, wAddr;
  logic [7:0] wData, lastData;
  logic [7:0] outVal = 8'h00;
  logic prot = 1'b0; // Fresh part starts unprotected
  logic protNext, idPage;
  logic weOld = 1'b0, rdOld = 1'b0, busy = 1'b0, inWin = 1'b0, togg = 1'b0;
  int seq = 0, winCnt = 0, progCnt = 0, lowCnt = 0;
  wire wrOn = !memCe_b && !memWe_b;
  wire rdOn = !memCe_b && !memOe_b && memWe_b;
  assign memDataIn = outVal;
  // Blank array at power-up
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
    for (int i = 0; i < 64; i++) idMem[i] = 8'h00;
  end
  // Command pairs advance the sequence; other bytes load the page
  task automatic takeByte(input logic [14:0] a, input logic [7:0] d);
    if (!inWin) protNext = prot;
    inWin = 1'b1;
    winCnt = 0;
    if ((seq == 0 || seq == 3) && a == CMD_ADDR_A && d == CMD_DATA_A) seq++;
    else if ((seq == 1 || seq == 4) && a == CMD_ADDR_B && d == CMD_DATA_B) seq++;
    else if (seq == 2 && a == CMD_ADDR_A && d == CMD_DATA_DIS3) seq = 3;
    else if (seq == 2 && a == CMD_ADDR_A && d == CMD_DATA_UNLOCK) begin
      seq = 6;
      protNext = 1'b1; // Armed when this cycle ends
    end else if (seq == 5 && a == CMD_ADDR_A && d == CMD_DATA_DIS6) begin
      seq = 6;
      protNext = 1'b0; // Cleared when this cycle ends
    end else begin
      if (!prot || seq == 6) begin // Unprefixed bytes dropped when armed
        page[a[5:0]] = d; // Low six bits pick the slot
        loaded[a[5:0]] = 1'b1;
        pageAddr = a;
        idPage = idHighVolt && a >= ID_ROW_BASE;
        lastData = d;
      end
      if (seq != 6) seq = 0;
    end
  endtask : takeByte
  // Pin sampling: write pulses, read pulses, load window, programming, read data
  always @(posedge clk) begin
    if (wrOn && !weOld) wAddr = memAddr; // Address on the later falling edge
    if (wrOn) wData = memDataOut;
    if (rdOn && !rdOld && busy) togg = !togg; // Each read pulse while busy flips bit six
    if (!wrOn && weOld && eraseHighVolt && lowCnt >= ERASE_MIN) // Long strobe sets all
      for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
    else if (!wrOn && weOld && memOe_b && !busy && lowCnt >= 4)
      takeByte(wAddr, wData);
    lowCnt = wrOn ? lowCnt + 1 : 0;
    if (inWin && !wrOn) winCnt++;
    if (inWin && (winCnt >= WIN || rdOn)) begin // Quiet window or a read ends the load
      inWin = 1'b0;
      busy = 1'b1;
      progCnt = 0;
    end
    if (busy) progCnt++;
    if (busy && progCnt >= PROG) begin // Self-timed cycle ends, loaded slots only
      for (int i = 0; i < 64; i++)
        if (loaded[i] && idPage) idMem[i] = page[i];
        else if (loaded[i]) mem[{pageAddr[14:6], 6'(i)}] = page[i];
      prot = protNext; // Kept until the disable pairs
      busy = 1'b0;
      loaded = '0;
      seq = 0;
    end
    if (rdOn && busy) outVal <= {~lastData[7], togg, lastData[5:0]};
    else if (rdOn && idHighVolt && memAddr >= ID_ROW_BASE) outVal <= idMem[memAddr[5:0]];
    else if (rdOn) outVal <= mem[memAddr]; // True data once idle
    else outVal <= ~outVal; // Released bus inverts its last value every cycle
    weOld = wrOn;
    rdOld = rdOn;
  end
endmodule : eeprom_dev_model

// [dv/tb_top.sv]
// Self-checking bench for the EEPROM host controller against the device model
`timescale 1ns/1ns
module tb_top;
  import eeprom_host_pkg::*;
  localparam int POWER = 20;
  localparam int ERASE = 60;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic powerGood = 1'b0;
  logic reqValid = 1'b0;
  logic reqProtected = 1'b0;
  logic reqIdRow = 1'b0;
  logic loadValid = 1'b0;
  op_t reqOp = OP_READ;
  logic [14:0] reqAddr = 15'h0000;
  logic [6:0] reqCount = 7'h00;
  logic [5:0] loadSlot = 6'h00;
  logic [7:0] loadData = 8'h00;
  logic reqReady, doneValid, doneTimeout, memCe_b, memOe_b, memWe_b;
  logic idHighVolt, eraseHighVolt, memDataOe;
  logic [7:0] doneData, memDataOut, memDataIn;
  logic [14:0] memAddr;
  int fails = 0;
  int checksDone = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  eeprom_host #(.POWER_CYCLES(POWER), .WRITE_CYCLE_CYCLES(2000), .ERASE_CYCLES(ERASE),
    .SETUP_CYCLES(20)) dut_u (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
    .powerGood(powerGood), .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
    .reqProtected(reqProtected), .reqIdRow(reqIdRow), .reqAddr(reqAddr), .reqCount(reqCount),
    .loadValid(loadValid), .loadSlot(loadSlot), .loadData(loadData), .doneValid(doneValid),
    .doneData(doneData), .doneTimeout(doneTimeout), .memAddr(memAddr), .memCe_b(memCe_b),
    .memOe_b(memOe_b), .memWe_b(memWe_b), .idHighVolt(idHighVolt),
    .eraseHighVolt(eraseHighVolt), .memDataOut(memDataOut), .memDataOe(memDataOe),
    .memDataIn(memDataIn));
  eeprom_dev_model #(.WIN(200), .PROG(120), .ERASE_MIN(ERASE)) dev_u (.clk(clk),
    .memAddr(memAddr), .memCe_b(memCe_b), .memOe_b(memOe_b), .memWe_b(memWe_b),
    .idHighVolt(idHighVolt), .eraseHighVolt(eraseHighVolt), .memDataOut(memDataOut),
    .memDataIn(memDataIn));
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // A wait that ran out ends the run as a mismatch
  task automatic hang();
    fails++;
    $display("BAD t=%0t seen=%h exp=%h", $time, 8'h00, 8'h01);
    summarize();
  endtask : hang
  // One request, its bytes right after the take, then the wait for completion
  task automatic run(input op_t op, input logic id, input logic pfx, input logic [14:0] addr,
      input int n, input logic [7:0] d0);
    int k;
    for (k = 0; k < 5000 && reqReady !== 1'b1; k++) @(negedge clk);
    if (k == 5000) hang();
    reqValid = 1'b1;
    reqOp = op;
    reqIdRow = id;
    reqProtected = pfx;
    reqAddr = addr;
    reqCount = 7'(n);
    @(negedge clk);
    reqValid = 1'b0;
    for (int i = 0; i < n; i++) begin
      loadValid = 1'b1;
      loadSlot = addr[5:0] + 6'(i);
      loadData = d0 + 8'(i);
      @(negedge clk);
    end
    loadValid = 1'b0;
    for (k = 0; k < 40000 && doneValid !== 1'b1; k++) @(negedge clk);
    if (k == 40000) hang();
    @(negedge clk);
  endtask : run
  // Read one location and compare
  task automatic rdChk(input logic id, input logic [14:0] addr, input logic [7:0] exp);
    run(OP_READ, id, 1'b0, addr, 0, 8'h00);
    check(doneData, exp);
  endtask : rdChk
  // No request is accepted before power good plus its delay
  task automatic tPower();
    int k;
    repeat (40) @(negedge clk);
    check(8'(reqReady), 8'h00);
    powerGood = 1'b1;
    for (k = 0; k < 500 && reqReady !== 1'b1; k++) @(negedge clk);
    check(8'(k >= POWER), 8'h01);
    check(8'(reqReady), 8'h01);
    $display("power-up test done");
  endtask : tPower
  // Short page on a fresh part, read back at once after polling
  task automatic tPage();
    run(OP_PAGE_WRITE, 1'b0, 1'b0, 15'h0100, 3, 8'h41);
    check(8'(doneTimeout), 8'h00);
    rdChk(1'b0, 15'h0100, 8'h41);
    rdChk(1'b0, 15'h0102, 8'h43);
    rdChk(1'b0, 15'h0103, 8'h00);
    $display("page test done");
  endtask : tPage
  // Full 64-byte page inside the load window
  task automatic tFull();
    run(OP_PAGE_WRITE, 1'b0, 1'b0, 15'h0240, 64, 8'h80);
    check(8'(doneTimeout), 8'h00);
    rdChk(1'b0, 15'h0240, 8'h80);
    rdChk(1'b0, 15'h027f, 8'hbf);
    $display("full page test done");
  endtask : tFull
  // Arm protection, drop a bare write, pass a prefixed one, then disarm
  task automatic tProt();
    run(OP_PROTECT_ON, 1'b0, 1'b0, 15'h0300, 0, 8'h00);
    run(OP_PAGE_WRITE, 1'b0, 1'b0, 15'h0300, 1, 8'h11);
    rdChk(1'b0, 15'h0300, 8'h00);
    run(OP_PAGE_WRITE, 1'b0, 1'b1, 15'h0300, 1, 8'h22);
    rdChk(1'b0, 15'h0300, 8'h22);
    run(OP_PROTECT_OFF, 1'b0, 1'b0, 15'h0300, 0, 8'h00);
    run(OP_PAGE_WRITE, 1'b0, 1'b0, 15'h0301, 1, 8'h33);
    rdChk(1'b0, 15'h0301, 8'h33);
    $display("protection test done");
  endtask : tProt
  // Identification row is separate from the main array
  task automatic tIdRow();
    run(OP_PAGE_WRITE, 1'b1, 1'b0, 15'h7fc5, 1, 8'h5a);
    rdChk(1'b0, 15'h7fc5, 8'h00);
    rdChk(1'b1, 15'h7fc5, 8'h5a);
    $display("id row test done");
  endtask : tIdRow
  // Whole-array erase leaves every byte high
  task automatic tErase();
    run(OP_ERASE, 1'b0, 1'b0, 15'h0000, 0, 8'h00);
    rdChk(1'b0, 15'h0100, 8'hff);
    $display("erase test done");
  endtask : tErase
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    tPower();
    tPage();
    tFull();
    tProt();
    tIdRow();
    tErase();
    summarize();
  end
endmodule : tb_top
